/* File: rtl/dwt_consts.svh */
`ifndef DWT_CONSTS_SVH
`define DWT_CONSTS_SVH
// Register map
`define DWT_ADDR_W 8
`define DWT_REG_COUNT_CONTROL 8'hd8
`define DWT_REG_RESET_VAL 8'hfe
// Field positions
`define DWT_BIT_ACTIVATE 0
`define DWT_BIT_SOFT_RESET 1
// Period field: six bits, register bit 7 is the counter LSB
`define DWT_PERIOD_BITS 6
`define DWT_BIT_PERIOD_LSB 7
// Clock: 200 MHz, 5 ns period
`define DWT_CLK_PERIOD_NS 5
// Internal clock divided by twelve, then by 256 for one counter step
`define DWT_DIV_CORE 12
`define DWT_DIV_PRESCALE 256
`define DWT_TICK_CYCLES (`DWT_DIV_CORE * `DWT_DIV_PRESCALE)
// Reset stretch after the source is removed, in divide-by-twelve ticks
`define DWT_RST_STRETCH_CYCLES 2048
`endif

/* File: rtl/dwt_pkg.sv */
package dwt_pkg;
   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dwt_bus_req_t;

   // Reset sequencer states
   typedef enum logic [1:0] {
      DWT_RUN = 2'b00,
      DWT_HOLD = 2'b01,
      DWT_STRETCH = 2'b10
   } dwt_rst_state_t;
endpackage

/* File: rtl/dwt_watchdog.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "dwt_consts.svh"

module dwt_watchdog
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Option and power control
   input wire logic hw_activation_i,
   input wire logic stop_req_i,
   input wire logic wake_irq_i,
   input wire logic ext_reset_req_i,
   // Register bus
   input wire dwt_pkg::dwt_bus_req_t bus_i,
   output logic [7:0] rdata_o,
   // System outputs
   output logic mcu_reset_o,
   output logic stop_mode_o,
   output logic wait_mode_o
);

   // Register image as software sees it
   logic [7:0] count_control;
   // Divider chain: twelve, then 256, giving one counter step
   logic [3:0] div12;
   logic [7:0] div256;
   logic tick;
   // Counter view and next-state terms
   logic active;
   logic [6:0] phys;
   logic [6:0] next_phys;
   logic [7:0] next_reg;
   logic wd_write;
   logic sr_fall;
   // Reset sequencer: the stretch counts divided ticks, not raw cycles
   logic [11:0] stretch_cnt;
   dwt_pkg::dwt_rst_state_t rst_state;
   logic rst_req;
   logic sync_rst;

   // Physical counter view: bit 6 is the soft-reset bit, 5..0 reversed period bits
   // bit reversal map
   function automatic logic [6:0] to_phys(input logic [7:0] r);
      logic [6:0] p;
      p = '0;
      p[`DWT_PERIOD_BITS] = r[`DWT_BIT_SOFT_RESET];
      for (int i = 0; i < `DWT_PERIOD_BITS; i++)
      begin
         p[i] = r[`DWT_BIT_PERIOD_LSB - i];
      end
      return p;
   endfunction

   // Inverse map; the activate bit never sits in the counter itself
   function automatic logic [7:0] from_phys(input logic [6:0] p, input logic act);
      logic [7:0] r;
      r = '0;
      r[`DWT_BIT_ACTIVATE] = act;
      r[`DWT_BIT_SOFT_RESET] = p[`DWT_PERIOD_BITS];
      for (int i = 0; i < `DWT_PERIOD_BITS; i++)
      begin
         r[`DWT_BIT_PERIOD_LSB - i] = p[i];
      end
      return r;
   endfunction

   assign active = hw_activation_i | count_control[`DWT_BIT_ACTIVATE];
   assign phys = to_phys(count_control);
   assign wd_write = bus_i.wr && (bus_i.addr == `DWT_REG_COUNT_CONTROL);

   // divide by twelve
   // Keeps running through the reset stretch, or the delay could never elapse;
   // restarts from zero in HOLD so every stretch is 2048 whole divided ticks
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         div12 <= 4'h0;
      end
      else if (rst_state == dwt_pkg::DWT_HOLD)
      begin
         div12 <= 4'h0;
      end
      else if (stop_mode_o && !wake_irq_i)
      begin
         div12 <= div12;
      end
      else if (div12 == 4'(`DWT_DIV_CORE - 1))
      begin
         div12 <= 4'h0;
      end
      else
      begin
         div12 <= div12 + 4'h1;
      end
   end

   // prescale by 256; prescaler frozen in STOP, resumes after wake
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         div256 <= 8'h00;
      end
      else if (sync_rst)
      begin
         div256 <= 8'h00;
      end
      else if (!(stop_mode_o && !wake_irq_i) && div12 == 4'(`DWT_DIV_CORE - 1))
      begin
         div256 <= div256 + 8'h01;
      end
   end

   // One counter step every 3072 cycles; no step while STOP is in force
   assign tick = !(stop_mode_o && !wake_irq_i) && (div12 == 4'(`DWT_DIV_CORE - 1))
                 && (div256 == 8'(`DWT_DIV_PRESCALE - 1));

   // Next register value; a write wins over the decrement in the same cycle
   // so a reload that meets a tick is never lost
   always_comb
   begin
      next_phys = phys;
      if (tick)
      begin
         next_phys = phys - 7'h01;
      end
      next_reg = from_phys(next_phys, count_control[`DWT_BIT_ACTIVATE]);
      if (wd_write)
      begin
         next_reg = bus_i.wdata;
         next_reg[`DWT_BIT_ACTIVATE] = bus_i.wdata[`DWT_BIT_ACTIVATE]
                                       | count_control[`DWT_BIT_ACTIVATE];
      end
      if (hw_activation_i)
      begin
         next_reg[`DWT_BIT_ACTIVATE] = 1'b1;
      end
   end

   // reset value; also reloaded whenever the internal reset is active
   // Writes during the stretch are thrown away on purpose
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         count_control <= `DWT_REG_RESET_VAL;
      end
      else if (sync_rst)
      begin
         count_control <= `DWT_REG_RESET_VAL;
      end
      else
      begin
         count_control <= next_reg;
      end
   end

   // bit 6 triggers; period is 1..64 ticks of 3072 cycles
   // no timeout while inactive
   // A write clearing the soft-reset bit still resets while inactive
   assign sr_fall = count_control[`DWT_BIT_SOFT_RESET] && !next_reg[`DWT_BIT_SOFT_RESET]
                    && (active || wd_write);
   assign rst_req = ext_reset_req_i || (!sync_rst && sr_fall);

   // stretch release
   // HOLD follows the external source; an external request in STRETCH
   // restarts the whole delay rather than shortening it
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_state <= dwt_pkg::DWT_STRETCH;
         stretch_cnt <= 12'h000;
      end
      else
      begin
         case (rst_state)
            dwt_pkg::DWT_RUN:
            begin
               if (rst_req)
               begin
                  rst_state <= dwt_pkg::DWT_HOLD;
               end
            end
            dwt_pkg::DWT_HOLD:
            begin
               stretch_cnt <= 12'h000;
               if (!ext_reset_req_i)
               begin
                  rst_state <= dwt_pkg::DWT_STRETCH;
               end
            end
            dwt_pkg::DWT_STRETCH:
            begin
               if (ext_reset_req_i)
               begin
                  rst_state <= dwt_pkg::DWT_HOLD;
               end
               else if (div12 == 4'(`DWT_DIV_CORE - 1))
               begin
                  if (stretch_cnt == 12'(`DWT_RST_STRETCH_CYCLES - 1))
                  begin
                     rst_state <= dwt_pkg::DWT_RUN;
                  end
                  stretch_cnt <= stretch_cnt + 12'h001;
               end
            end
            default:
            begin
               rst_state <= dwt_pkg::DWT_HOLD;
            end
         endcase
      end
   end

   assign sync_rst = (rst_state != dwt_pkg::DWT_RUN);

   // Divider keeps running during the stretch so the delay can elapse
   // Output reset flop
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         mcu_reset_o <= 1'b1;
      end
      else
      begin
         mcu_reset_o <= sync_rst || rst_req;
      end
   end

   // wake clears STOP
   // The option input or the activate bit keeps the clock alive, so STOP degrades to WAIT
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stop_mode_o <= 1'b0;
         wait_mode_o <= 1'b0;
      end
      else if (sync_rst || wake_irq_i)
      begin
         stop_mode_o <= 1'b0;
         wait_mode_o <= 1'b0;
      end
      else if (stop_req_i)
      begin
         stop_mode_o <= !active;
         wait_mode_o <= active;
      end
   end

   // Read data, one cycle after the strobe; unmapped reads return zero
   // The option input is ORed in so a read shows the bit set whenever the option input is high
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (bus_i.rd && bus_i.addr == `DWT_REG_COUNT_CONTROL)
      begin
         rdata_o <= count_control | {7'h00, hw_activation_i};
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

endmodule

/* File: test/dwt_watchdog_checker.sv */
`timescale 1ns/10ps
module dwt_watchdog_checker (
   // Watched ports
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic hw_activation_i,
   input wire logic stop_req_i,
   input wire logic wake_irq_i,
   input wire logic ext_reset_req_i,
   input wire dwt_pkg::dwt_bus_req_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic mcu_reset_o,
   input wire logic stop_mode_o,
   input wire logic wait_mode_o
);
   logic [14:0] hold_cnt;
   logic rd_q;
   logic act_seen;
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // Cycles held in reset, saturating so a long hold cannot wrap
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hold_cnt <= 15'h0;
      end
      else if (!mcu_reset_o)
      begin
         hold_cnt <= 15'h0;
      end
      else if (hold_cnt != 15'h7fff)
      begin
         hold_cnt <= hold_cnt + 15'h1;
      end
   end
   // Pending read, and activation once seen on a read
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i)
      begin
         rd_q <= 1'b0;
         act_seen <= 1'b0;
      end
      else
      begin
         rd_q <= bus_i.rd && bus_i.addr == 8'hd8;
         act_seen <= !mcu_reset_o && (act_seen || (rd_q && rdata_o[0]));
      end
   sequence s_hw_stop;
      hw_activation_i && stop_req_i && !wake_irq_i && !mcu_reset_o && !ext_reset_req_i;
   endsequence
   sequence s_wake;
      stop_mode_o && wake_irq_i && !stop_req_i;
   endsequence
   a_hw_wait: assert property (s_hw_stop |=> wait_mode_o) else $error("no wait");
   a_stop_gate: assert property (stop_mode_o |-> !hw_activation_i && !wait_mode_o) else $error("stop");
   a_stop_wake: assert property (s_wake |=> !stop_mode_o) else $error("no wake");
   a_stop_stays: assert property (stop_mode_o && !wake_irq_i && !ext_reset_req_i |=> stop_mode_o)
      else $error("stop lost");
   a_hw_bit_one: assert property (rd_q && hw_activation_i && !mcu_reset_o |-> rdata_o[0])
      else $error("hw bit");
   a_act_sticky: assert property (rd_q && act_seen && !mcu_reset_o |-> rdata_o[0])
      else $error("act lost");
   a_rd_idle: assert property (!rd_q |-> rdata_o == 8'h00) else $error("rdata");
   a_rst_hold: assert property ($fell(mcu_reset_o) |-> hold_cnt >= 15'h6000) else $error("short");
endmodule
bind dwt_watchdog dwt_watchdog_checker i_dwt_watchdog_checker (.ref_clk_i(ref_clk_i),
   .arst_n_i(arst_n_i), .hw_activation_i(hw_activation_i), .stop_req_i(stop_req_i),
   .wake_irq_i(wake_irq_i), .ext_reset_req_i(ext_reset_req_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .mcu_reset_o(mcu_reset_o), .stop_mode_o(stop_mode_o),
   .wait_mode_o(wait_mode_o));

/* File: test/digital_watchdog_timer_tb.sv */
`timescale 1ns/10ps
module digital_watchdog_timer_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hw = 1'b0;
   logic stp = 1'b0;
   logic wk = 1'b0;
   logic ext = 1'b0;
   dwt_pkg::dwt_bus_req_t bus = '0;
   logic [7:0] rdat;
   logic [7:0] last;
   logic mrst, smode, wmode;
   logic rd_q = 1'b0;
   logic [7:0] exp_q[$];
   logic [16:0] lfsr = 17'h129ba;
   int mismatches = 0;
   int comparisons = 0;
   // Bench clock
   always #2.5 clk = ~clk;
   dwt_watchdog i_dwt_watchdog (.ref_clk_i(clk), .arst_n_i(rst_n), .hw_activation_i(hw),
      .stop_req_i(stp), .wake_irq_i(wk), .ext_reset_req_i(ext), .bus_i(bus),
      .rdata_o(rdat), .mcu_reset_o(mrst), .stop_mode_o(smode), .wait_mode_o(wmode));
   // Step of the stimulus generator
   function logic [16:0] step(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task chk(input string n, input logic [7:0] s, e);
      comparisons++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read data arrives one cycle after the strobe; polls leave no note
   always @(posedge clk)
   begin
      if (rd_q)
      begin
         last = rdat;
         if (exp_q.size() > 0)
            chk("rd", rdat, exp_q.pop_front());
      end
      rd_q <= bus.rd;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bus cycles: one-cycle strobes, extra wait after a read lets the monitor land first
   task wr(input logic [7:0] d);
      bus.wdata <= d;
      bus.wr <= 1'b1;
      cyc(1);
      bus.wr <= 1'b0;
   endtask
   task rd(input logic c, input logic [7:0] e);
      if (c)
         exp_q.push_back(e);
      bus.rd <= 1'b1;
      cyc(1);
      bus.rd <= 1'b0;
      cyc(2);
   endtask
   task pulse(input logic w);
      stp <= !w;
      wk <= w;
      cyc(1);
      stp <= 1'b0;
      wk <= 1'b0;
      cyc(1);
   endtask
   task wait_rst(input logic v, input int n);
      for (int i = 0; i < n && mrst !== v; i++)
         cyc(1);
      chk("rst", {7'h0, mrst}, {7'h0, v});
      if (mrst !== v)
         finish_test;
   endtask
   // Reset is still up 24000 cycles into the 24576-cycle stretch, then must fall within 1000 more
   task hold;
      cyc(24000);
      chk("rst", {7'h0, mrst}, 8'h01);
      wait_rst(1'b0, 1000);
   endtask
   // Poll until the counter steps, then compare the new value
   task poll(input logic [7:0] o, e);
      last = o;
      for (int i = 0; i < 1100 && last === o; i++)
         rd(1'b0, 8'h00);
      chk("count", last, e);
      if (last === o)
         finish_test;
   endtask
   // Main sequence
   initial
   begin
      bus.addr <= 8'hd8;
      cyc(4);
      rst_n <= 1'b1;
      cyc(20);
      ext <= 1'b1;
      cyc(1);
      ext <= 1'b0;
      cyc(24570);
      chk("rst", {7'h0, mrst}, 8'h01);
      wait_rst(1'b0, 100);
      rd(1'b1, 8'hfe);
      bus.addr <= 8'h10;
      rd(1'b1, 8'h00);
      bus.addr <= 8'hd8;
      $display("reset test done");
      wr(8'h82);
      poll(8'h82, 8'h02);
      poll(8'h02, 8'hfc);
      chk("rst", {7'h0, mrst}, 8'h00);
      pulse(1'b0);
      chk("stop", {7'h0, smode}, 8'h01);
      pulse(1'b1);
      chk("stop", {7'h0, smode}, 8'h00);
      $display("timer test done");
      wr(8'hff);
      rd(1'b1, 8'hff);
      wr(8'hfe);
      rd(1'b1, 8'hff);
      pulse(1'b0);
      chk("stop", {7'h0, smode}, 8'h00);
      pulse(1'b1);
      lfsr = step(lfsr);
      wr({lfsr[5:0], 2'b01});
      wait_rst(1'b1, 4);
      hold;
      rd(1'b1, 8'hfe);
      $display("soft reset test done");
      wr(8'h03);
      wait_rst(1'b1, 3100);
      hw <= 1'b1;
      hold;
      rd(1'b1, 8'hff);
      pulse(1'b0);
      chk("wait", {7'h0, wmode}, 8'h01);
      chk("stop", {7'h0, smode}, 8'h00);
      $display("timeout test done");
      finish_test;
   end
endmodule
